// ===== rtl/tse_axil_slave.sv
// Purpose: AXI4-Lite slave turning bus transfers into register strobes
// Assumes: one write and one read outstanding at most
// Notes: address and data are taken in either order
`default_nettype none
module tse_axil_slave
  import tse_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic [31:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  // read channels
  input wire logic [31:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  // register strobes
  tse_reg_if.bus regs
);
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tse_axil_state_t;

  tse_axil_state_t s_reg, s_next;

  assign regs.wr_en = s_reg.aw_got && s_reg.w_got;
  assign regs.wr_addr = s_reg.awaddr;
  assign regs.wr_data = s_reg.wdata;
  assign regs.wr_strb = s_reg.wstrb;
  assign regs.rd_en = s_axil_arvalid && s_reg.arready;
  assign regs.rd_addr = s_axil_araddr;

  always_comb begin
    s_next = s_reg;
    if (s_axil_awvalid && s_reg.awready) begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = s_axil_awaddr;
    end
    if (s_axil_wvalid && s_reg.wready) begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axil_wdata;
      s_next.wstrb = s_axil_wstrb;
    end
    if (s_reg.bvalid && s_axil_bready) begin
      s_next.bvalid = 1'b0;
    end
    // the core acts on the strobe in this cycle; the response follows at the edge
    if (s_reg.aw_got && s_reg.w_got) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = regs.wr_ok ? TSE_RESP_OKAY : TSE_RESP_SLVERR;
    end
    if (s_reg.rvalid && s_axil_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axil_arvalid && s_reg.arready) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = regs.rd_data;
      s_next.rresp = regs.rd_ok ? TSE_RESP_OKAY : TSE_RESP_SLVERR;
    end
    // ready stays low while a response is pending, which throttles the master
    s_next.awready = !s_next.aw_got && !s_next.bvalid;
    s_next.wready = !s_next.w_got && !s_next.bvalid;
    s_next.arready = !s_next.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axil_awready = s_reg.awready;
  assign s_axil_wready = s_reg.wready;
  assign s_axil_bvalid = s_reg.bvalid;
  assign s_axil_bresp = s_reg.bresp;
  assign s_axil_arready = s_reg.arready;
  assign s_axil_rvalid = s_reg.rvalid;
  assign s_axil_rdata = s_reg.rdata;
  assign s_axil_rresp = s_reg.rresp;
endmodule
`default_nettype wire

// ===== rtl/tse_channel.sv
// Purpose: per-channel reaction to a software capture/compare request
// Assumes: request is a one-cycle pulse on the core clock
// Notes: flag outputs are set pulses for the external flag register
`default_nettype none
module tse_channel
  import tse_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // request and context
  input wire logic req,
  input wire logic is_input,
  input wire logic flag_in,
  input wire logic [TSE_CNT_W-1:0] counter_value,
  // results
  output logic irq_set,
  output logic missed_set,
  output logic capture_strobe,
  output logic [TSE_CNT_W-1:0] capture_value
);
  typedef struct packed {
    logic irq_set;
    logic missed_set;
    logic capture_strobe;
    logic [TSE_CNT_W-1:0] capture_value;
  } tse_chan_state_t;

  tse_chan_state_t s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    s_next.irq_set = req; // R02 R03
    // a flag still pending means software has not yet read the last capture
    s_next.missed_set = req && is_input && flag_in; // R04
    s_next.capture_strobe = req && is_input; // R03
    if (req && is_input) begin
      s_next.capture_value = counter_value; // R03
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign irq_set = s_reg.irq_set;
  assign missed_set = s_reg.missed_set;
  assign capture_strobe = s_reg.capture_strobe;
  assign capture_value = s_reg.capture_value;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_req_out;
    req && !is_input;
  endsequence
  sequence s_req_in;
    req && is_input;
  endsequence

  property p_out_flag_only;
    s_req_out |=> irq_set && !capture_strobe && !missed_set;
  endproperty
  a_out_flag_only: assert property (p_out_flag_only) // R02
    else $error("output channel request did not set only the flag");

  property p_in_capture;
    s_req_in |=> irq_set && capture_strobe && capture_value == $past(counter_value);
  endproperty
  a_in_capture: assert property (p_in_capture) // R03
    else $error("input channel request did not capture the counter");

  property p_missed;
    s_req_in ##0 flag_in |=> missed_set ##1 !missed_set || $past(req);
  endproperty
  a_missed: assert property (p_missed) // R04
    else $error("missed capture not flagged exactly once");

  property p_no_spurious;
    !req |=> !irq_set && !capture_strobe;
  endproperty
  a_no_spurious: assert property (p_no_spurious) // R02
    else $error("channel event without a request");
endmodule
`default_nettype wire

// ===== rtl/tse_pkg.sv
// Purpose: shared constants and types for the timer software event block
// Assumes: 32-bit register bus, one aligned word per register
// Notes: offsets are full byte addresses of the two timer instances
`default_nettype none
package tse_pkg;
  localparam int unsigned TSE_CNT_W = 16;
  localparam int unsigned TSE_NUM_CH = 4;

  // register byte addresses
  localparam logic [31:0] TSE_T1_EVENT_ADDR = 32'h4000e014;
  localparam logic [31:0] TSE_T1_MODE1_ADDR = 32'h4000e018;
  localparam logic [31:0] TSE_T1_MODE2_ADDR = 32'h4000e01c;
  localparam logic [31:0] TSE_T2_EVENT_ADDR = 32'h4000f014;
  localparam logic [31:0] TSE_T2_MODE1_ADDR = 32'h4000f018;
  localparam logic [31:0] TSE_T2_MODE2_ADDR = 32'h4000f01c;

  // reset values
  localparam logic [31:0] TSE_EVENT_RESET = 32'h0000_0000;
  localparam logic [15:0] TSE_MODE_RESET = 16'h0000;

  // event request bit positions
  localparam int unsigned TSE_EV_UPDATE = 0;
  localparam int unsigned TSE_EV_CHAN1 = 1;
  localparam int unsigned TSE_EV_TRIGGER = 6;

  // mode register layout: one byte per channel, channel 2 of each register at +8
  localparam logic [15:0] TSE_MODE_MASK = 16'h7f7f;
  localparam int unsigned TSE_CH_STRIDE = 8;
  localparam int unsigned TSE_SEL_LSB = 0;
  localparam int unsigned TSE_OFE_BIT = 2;
  localparam int unsigned TSE_OBE_BIT = 3;
  localparam int unsigned TSE_OM_LSB = 4;
  localparam int unsigned TSE_IPSC_LSB = 2;
  localparam int unsigned TSE_IF_LSB = 4;
  localparam logic [1:0] TSE_SEL_OUTPUT = 2'h0;

  // bus responses
  localparam logic [1:0] TSE_RESP_OKAY = 2'h0;
  localparam logic [1:0] TSE_RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ===== rtl/tse_reg_if.sv
// Purpose: register access strobes between the bus slave and the core
// Assumes: write and read are each one-cycle strobes
// Notes: ok and read data are combinational answers to the strobe
`default_nettype none
interface tse_reg_if;
  logic wr_en;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic rd_en;
  logic [31:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
               input wr_ok, rd_data, rd_ok);
  modport core (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                output wr_ok, rd_data, rd_ok);
endinterface
`default_nettype wire

// ===== rtl/tse_timer_sw_event.sv
// Purpose: software event generation and channel direction for one timer
// Assumes: counter, prescaler and flag register sit outside on the same clock
// Notes: TIMER_INDEX picks which timer's addresses this instance decodes
//
// Summary of operation
// R01 - writing one to the trigger bit sets the trigger interrupt flag
// R02 - channel request on an output channel sets its interrupt flag
// R03 - channel request on an input channel captures the counter and sets flag
// R04 - capture request with flag already set also sets missed-capture flag
// R05 - update request reloads counter and fires an update event
// R06 - update request clears prescaler count, ratio untouched
// R07 - update in center-aligned or up-counting mode clears the counter
// R08 - update in edge-aligned down-counting loads the auto-reload value
// R09 - each channel's selection field picks input capture or output compare
// R10 - output fields act only at selection zero, input fields above zero
// R11 - event request bits are pulses and read back as zero
//
// Implementation choice: register access over AXI4-Lite.
`default_nettype none
module tse_timer_sw_event
  import tse_pkg::*;
#(
  parameter int unsigned TIMER_INDEX = 1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [31:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [31:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  // counter context
  input wire logic [tse_pkg::TSE_CNT_W-1:0] counter_value,
  input wire logic [tse_pkg::TSE_CNT_W-1:0] auto_reload_value,
  input wire logic count_direction,
  input wire logic center_aligned_mode,
  input wire logic [tse_pkg::TSE_NUM_CH-1:0] chan_irq_flag,
  // flag and counter control
  output logic trigger_irq_flag_set,
  output logic [tse_pkg::TSE_NUM_CH-1:0] chan_irq_flag_set,
  output logic [tse_pkg::TSE_NUM_CH-1:0] chan_missed_capture_set,
  output logic [tse_pkg::TSE_NUM_CH-1:0] chan_capture_strobe,
  output logic [tse_pkg::TSE_NUM_CH-1:0][tse_pkg::TSE_CNT_W-1:0] chan_compare_value,
  output logic update_event,
  output logic counter_reload,
  output logic [tse_pkg::TSE_CNT_W-1:0] counter_reload_value,
  output logic prescaler_clear,
  // channel configuration
  output logic [tse_pkg::TSE_NUM_CH-1:0] chan_is_input,
  output logic [tse_pkg::TSE_NUM_CH-1:0][2:0] chan_output_mode,
  output logic [tse_pkg::TSE_NUM_CH-1:0] chan_compare_buffer_en,
  output logic [tse_pkg::TSE_NUM_CH-1:0] chan_output_fast_en,
  output logic [tse_pkg::TSE_NUM_CH-1:0][2:0] chan_input_filter,
  output logic [tse_pkg::TSE_NUM_CH-1:0][1:0] chan_input_prescale
);
  localparam logic [31:0] EVENT_ADDR = (TIMER_INDEX == 2) ? TSE_T2_EVENT_ADDR
                                                          : TSE_T1_EVENT_ADDR;
  localparam logic [31:0] MODE1_ADDR = (TIMER_INDEX == 2) ? TSE_T2_MODE1_ADDR
                                                          : TSE_T1_MODE1_ADDR;
  localparam logic [31:0] MODE2_ADDR = (TIMER_INDEX == 2) ? TSE_T2_MODE2_ADDR
                                                          : TSE_T1_MODE2_ADDR;

  typedef struct packed {
    logic [15:0] mode1;
    logic [15:0] mode2;
    logic trig_set;
    logic upd;
    logic [TSE_CNT_W-1:0] reload_val;
    logic [TSE_NUM_CH-1:0] is_input;
    logic [TSE_NUM_CH-1:0][2:0] om;
    logic [TSE_NUM_CH-1:0] obe;
    logic [TSE_NUM_CH-1:0] ofe;
    logic [TSE_NUM_CH-1:0][2:0] icf;
    logic [TSE_NUM_CH-1:0][1:0] ipsc;
  } tse_core_state_t;

  tse_core_state_t s_reg, s_next;
  tse_reg_if regs ();
  logic ev_wr;
  logic [TSE_NUM_CH-1:0] ch_req;

  tse_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axil_awaddr(s_axil_awaddr),
    .s_axil_awvalid(s_axil_awvalid),
    .s_axil_awready(s_axil_awready),
    .s_axil_wdata(s_axil_wdata),
    .s_axil_wstrb(s_axil_wstrb),
    .s_axil_wvalid(s_axil_wvalid),
    .s_axil_wready(s_axil_wready),
    .s_axil_bresp(s_axil_bresp),
    .s_axil_bvalid(s_axil_bvalid),
    .s_axil_bready(s_axil_bready),
    .s_axil_araddr(s_axil_araddr),
    .s_axil_arvalid(s_axil_arvalid),
    .s_axil_arready(s_axil_arready),
    .s_axil_rdata(s_axil_rdata),
    .s_axil_rresp(s_axil_rresp),
    .s_axil_rvalid(s_axil_rvalid),
    .s_axil_rready(s_axil_rready),
    .regs(regs.bus)
  );

  // only byte lane 0 carries request bits; a write without it requests nothing
  assign ev_wr = regs.wr_en && regs.wr_addr == EVENT_ADDR && regs.wr_strb[0];

  always_comb begin
    for (int k = 0; k < TSE_NUM_CH; k++) begin
      ch_req[k] = ev_wr && regs.wr_data[TSE_EV_CHAN1 + k]; // R02 R03
    end
  end

  // register decode
  always_comb begin
    regs.wr_ok = regs.wr_addr == EVENT_ADDR || regs.wr_addr == MODE1_ADDR
                 || regs.wr_addr == MODE2_ADDR;
    regs.rd_ok = 1'b1;
    regs.rd_data = 32'h0000_0000;
    if (regs.rd_addr == MODE1_ADDR) begin
      regs.rd_data = {16'h0000, s_reg.mode1};
    end else if (regs.rd_addr == MODE2_ADDR) begin
      regs.rd_data = {16'h0000, s_reg.mode2};
    end else if (regs.rd_addr == EVENT_ADDR) begin
      regs.rd_data = TSE_EVENT_RESET; // R11
    end else begin
      regs.rd_ok = 1'b0;
    end
  end

  always_comb begin
    logic [7:0] fld;
    fld = 8'h00;
    s_next = s_reg;
    if (regs.wr_en && regs.wr_addr == MODE1_ADDR) begin
      for (int b = 0; b < 2; b++) begin
        if (regs.wr_strb[b]) begin
          s_next.mode1[b*8 +: 8] = regs.wr_data[b*8 +: 8] & TSE_MODE_MASK[b*8 +: 8];
        end
      end
    end
    if (regs.wr_en && regs.wr_addr == MODE2_ADDR) begin
      for (int b = 0; b < 2; b++) begin
        if (regs.wr_strb[b]) begin
          s_next.mode2[b*8 +: 8] = regs.wr_data[b*8 +: 8] & TSE_MODE_MASK[b*8 +: 8];
        end
      end
    end
    // requests are not stored: each pulse lasts exactly one cycle
    s_next.trig_set = ev_wr && regs.wr_data[TSE_EV_TRIGGER]; // R01 R11
    s_next.upd = ev_wr && regs.wr_data[TSE_EV_UPDATE]; // R05 R06 R11
    if (s_next.upd) begin
      if (center_aligned_mode || !count_direction) begin
        s_next.reload_val = '0; // R07
      end else begin
        s_next.reload_val = auto_reload_value; // R08
      end
    end
    for (int k = 0; k < TSE_NUM_CH; k++) begin
      // the modulo keeps the index in range in the branch that is not taken
      if (k < 2) begin
        fld = s_next.mode1[(k % 2)*TSE_CH_STRIDE +: 8];
      end else begin
        fld = s_next.mode2[(k % 2)*TSE_CH_STRIDE +: 8];
      end
      s_next.is_input[k] = fld[TSE_SEL_LSB +: 2] != TSE_SEL_OUTPUT; // R09
      // fields of the inactive direction are forced to zero here, before they are registered
      if (s_next.is_input[k]) begin
        s_next.om[k] = 3'h0; // R10
        s_next.obe[k] = 1'b0;
        s_next.ofe[k] = 1'b0;
        s_next.icf[k] = fld[TSE_IF_LSB +: 3]; // R10
        s_next.ipsc[k] = fld[TSE_IPSC_LSB +: 2];
      end else begin
        s_next.om[k] = fld[TSE_OM_LSB +: 3]; // R10
        s_next.obe[k] = fld[TSE_OBE_BIT];
        s_next.ofe[k] = fld[TSE_OFE_BIT];
        s_next.icf[k] = 3'h0; // R10
        s_next.ipsc[k] = 2'h0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  genvar g;
  generate
    for (g = 0; g < TSE_NUM_CH; g++) begin : g_chan
      tse_channel u_chan (
        .aclk(aclk),
        .aresetn(aresetn),
        .req(ch_req[g]),
        .is_input(s_reg.is_input[g]),
        .flag_in(chan_irq_flag[g]),
        .counter_value(counter_value),
        .irq_set(chan_irq_flag_set[g]),
        .missed_set(chan_missed_capture_set[g]),
        .capture_strobe(chan_capture_strobe[g]),
        .capture_value(chan_compare_value[g])
      );
    end
  endgenerate

  assign trigger_irq_flag_set = s_reg.trig_set;
  assign update_event = s_reg.upd;
  assign counter_reload = s_reg.upd;
  assign prescaler_clear = s_reg.upd;
  assign counter_reload_value = s_reg.reload_val;
  assign chan_is_input = s_reg.is_input;
  assign chan_output_mode = s_reg.om;
  assign chan_compare_buffer_en = s_reg.obe;
  assign chan_output_fast_en = s_reg.ofe;
  assign chan_input_filter = s_reg.icf;
  assign chan_input_prescale = s_reg.ipsc;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_upd_req;
    ev_wr && regs.wr_data[TSE_EV_UPDATE];
  endsequence

  property p_trig_set;
    ev_wr && regs.wr_data[TSE_EV_TRIGGER] |=> trigger_irq_flag_set ##1 !trigger_irq_flag_set
      || $past(ev_wr);
  endproperty
  a_trig_set: assert property (p_trig_set) // R01
    else $error("trigger request did not pulse the trigger flag");

  property p_trig_quiet;
    !(ev_wr && regs.wr_data[TSE_EV_TRIGGER]) |=> !trigger_irq_flag_set;
  endproperty
  a_trig_quiet: assert property (p_trig_quiet) // R01
    else $error("trigger flag set without a request");

  property p_update;
    s_upd_req |=> update_event && counter_reload;
  endproperty
  a_update: assert property (p_update) // R05
    else $error("update request did not reload the counter");

  property p_psc_clear;
    update_event |-> prescaler_clear && counter_reload
      && $past(ev_wr && regs.wr_data[TSE_EV_UPDATE]);
  endproperty
  a_psc_clear: assert property (p_psc_clear) // R06
    else $error("update event without prescaler clear");

  property p_clear_up;
    s_upd_req ##0 (center_aligned_mode || !count_direction) |=> counter_reload_value == '0;
  endproperty
  a_clear_up: assert property (p_clear_up) // R07
    else $error("update did not clear the counter");

  property p_load_down;
    s_upd_req ##0 (!center_aligned_mode && count_direction)
      |=> counter_reload_value == $past(auto_reload_value);
  endproperty
  a_load_down: assert property (p_load_down) // R08
    else $error("down-count update did not load auto-reload value");

  property p_dir_select;
    regs.wr_en && regs.wr_addr == MODE1_ADDR && regs.wr_strb[0]
      |=> chan_is_input[0] == ($past(regs.wr_data[1:0]) != TSE_SEL_OUTPUT);
  endproperty
  a_dir_select: assert property (p_dir_select) // R09
    else $error("channel 1 direction does not follow its selection field");

  property p_fields_gated;
    chan_is_input[0] |-> chan_output_mode[0] == 3'h0 && !chan_compare_buffer_en[0];
  endproperty
  a_fields_gated: assert property (p_fields_gated) // R10
    else $error("output fields active on an input channel");

  property p_input_fields_gated;
    !chan_is_input[0] |-> chan_input_filter[0] == 3'h0 && chan_input_prescale[0] == 2'h0;
  endproperty
  a_input_fields_gated: assert property (p_input_fields_gated) // R10
    else $error("input fields active on an output channel");

  property p_event_reads_zero;
    regs.rd_en && regs.rd_addr == EVENT_ADDR |=> s_axil_rvalid && s_axil_rdata == '0;
  endproperty
  a_event_reads_zero: assert property (p_event_reads_zero) // R11
    else $error("event register read back nonzero");
endmodule
`default_nettype wire

// ===== testbench/tse_timer_sw_event_bench.sv
// Purpose: self-checking bench for the timer software event block
// Assumes: timer 1 address set, bus master waits on every handshake
// Notes: random modes and requests, with all-zero, all-ones and masked-lane words
`default_nettype none
module tse_timer_sw_event_bench import tse_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn;
  logic [31:0] awaddr, wdata, araddr, rdata, d, m1, m2, mode, rv;
  logic [3:0] wstrb, flag, isin, cflag, miss, cstb, is_in, fast_en, buf_en;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, s_resp, rr;
  logic [15:0] cnt, arr, s_fx, s_rv, reload_val;
  logic [3:0][15:0] cap_val, ecap;
  logic [3:0][2:0] omode, ifilt;
  logic [3:0][1:0] ipsc;
  logic dir, ctr, trig, upd, reload, pclr;
  int fails, total_checks;

  tse_timer_sw_event #(.TIMER_INDEX(1)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
    .s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid),
    .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid),
    .s_axil_bready(bready), .s_axil_araddr(araddr), .s_axil_arvalid(arvalid),
    .s_axil_arready(arready), .s_axil_rdata(rdata), .s_axil_rresp(rresp),
    .s_axil_rvalid(rvalid), .s_axil_rready(rready), .counter_value(cnt),
    .auto_reload_value(arr), .count_direction(dir), .center_aligned_mode(ctr),
    .chan_irq_flag(flag), .trigger_irq_flag_set(trig), .chan_irq_flag_set(cflag),
    .chan_missed_capture_set(miss), .chan_capture_strobe(cstb),
    .chan_compare_value(cap_val), .update_event(upd), .counter_reload(reload),
    .counter_reload_value(reload_val), .prescaler_clear(pclr), .chan_is_input(is_in),
    .chan_output_mode(omode), .chan_compare_buffer_en(buf_en),
    .chan_output_fast_en(fast_en), .chan_input_filter(ifilt),
    .chan_input_prescale(ipsc));

  always #4 aclk = ~aclk;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // pulses only live for the cycle in which bvalid first rises, so grab them there
  task automatic wr(input logic [31:0] a, input logic [31:0] dw, input logic [3:0] s);
    logic aw_hs, w_hs, done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= dw;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 40 && !done; i++) begin
      @(negedge aclk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      if (bvalid === 1'b1) begin
        done = 1'b1;
        s_fx = {pclr, reload, upd, trig, cstb, miss, cflag};
        s_rv = reload_val;
        s_resp = bresp;
      end
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!done) chk(0, 1, "write stuck");
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] dr, output logic [1:0] rs);
    logic ar_hs, done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 40 && !done; i++) begin
      @(negedge aclk);
      ar_hs = arvalid && arready;
      if (rvalid === 1'b1) begin
        done = 1'b1;
        dr = rdata;
        rs = rresp;
      end
      @(posedge aclk);
      if (ar_hs) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!done) chk(0, 1, "read stuck");
  endtask

  function automatic logic [15:0] exp_fx(input logic [31:0] dv, input logic [3:0] ci,
      input logic [3:0] fl);
    return {{3{dv[0]}}, dv[6], dv[4:1] & ci, dv[4:1] & ci & fl, dv[4:1]};
  endfunction

  task automatic chk_cfg(input int c, input logic [7:0] b);
    logic o;
    o = (b[1:0] == TSE_SEL_OUTPUT);
    chk(is_in[c], !o, "direction");
    chk({omode[c], buf_en[c], fast_en[c]}, o ? b[6:2] : 5'h0, "output fields");
    chk({ifilt[c], ipsc[c]}, o ? 5'h0 : b[6:2], "input fields");
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awaddr, wdata, araddr, wstrb, awvalid, wvalid, bready, arvalid, rready} = '0;
    {cnt, arr, dir, ctr, flag} = '0;
    ecap = '0;
    void'($urandom(57508));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(TSE_T1_MODE1_ADDR, rv, rr);
    chk({rr, rv}, {TSE_RESP_OKAY, 32'h0}, "mode reset");
    for (int n = 0; n < 16; n++) begin
      m1 = $urandom;
      m2 = $urandom;
      wr(TSE_T1_MODE1_ADDR, m1, 4'hf);
      wr(TSE_T1_MODE2_ADDR, m2, 4'hf);
      mode = {m2[15:0], m1[15:0]} & {2{TSE_MODE_MASK}};
      rd(TSE_T1_MODE1_ADDR, rv, rr);
      chk(rv, mode[15:0], "mode readback");
      rd(TSE_T1_MODE2_ADDR, rv, rr);
      chk({rr, rv}, {TSE_RESP_OKAY, 16'h0, mode[31:16]}, "mode 2 readback");
      for (int c = 0; c < 4; c++) begin
        chk_cfg(c, mode[8*c +: 8]);
        isin[c] = (mode[8*c +: 2] != TSE_SEL_OUTPUT);
      end
      cnt <= 16'($urandom);
      arr <= 16'($urandom);
      dir <= 1'($urandom);
      ctr <= 1'($urandom);
      flag <= (n == 1) ? 4'hf : 4'($urandom);
      d = (n == 0) ? 32'h0 : (n < 3) ? 32'h7f : $urandom;
      // lane 0 masked off: the request byte never arrives
      wr(TSE_T1_EVENT_ADDR, d, (n == 2) ? 4'he : 4'hf);
      if (n == 2) d = 32'h0;
      chk({s_resp, s_fx}, {TSE_RESP_OKAY, exp_fx(d, isin, flag)}, "pulses");
      if (d[0]) chk(s_rv, (ctr || !dir) ? 16'h0 : arr, "reload value");
      for (int c = 0; c < 4; c++) begin
        if (d[c+1] && isin[c]) ecap[c] = cnt;
        chk(cap_val[c], ecap[c], "captured count");
      end
      rd(TSE_T1_EVENT_ADDR, rv, rr);
      chk({rr, rv}, {TSE_RESP_OKAY, 32'h0}, "request readback");
    end
    wr(32'h4000e000, 32'h7f, 4'hf);
    chk({s_resp, s_fx}, {TSE_RESP_SLVERR, 16'h0}, "unmapped write");
    rd(32'h4000e000, rv, rr);
    chk({rr, rv}, {TSE_RESP_SLVERR, 32'h0}, "unmapped read");
    stop_test();
  end

  // the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    fails++;
    $display("BAD t=%0t watchdog expired", $time);
    stop_test();
  end
endmodule
`default_nettype wire
